// ===== hw/read_transposer.sv
// Buffer read path that transposes data on request
`timescale 1ns/1ps
module read_transposer (
  input  wire logic         clk_i,     // Clock
  input  wire logic         reset_i,   // Synchronous reset
  input  wire logic         valid_i,   // Read data present
  input  wire logic [511:0] data_i,    // Data as stored
  input  wire logic         xpose_i,   // Transpose this read
  output logic              valid_o,   // Delivered data present
  output logic [511:0]      data_o     // Delivered data
);

  // *****************************************************
  // One register stage, transposed or straight
  // *****************************************************
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      valid_o <= 1'b0;
      data_o  <= '0;
    end else begin
      valid_o <= valid_i;
      if (valid_i && xpose_i) begin
        data_o <= wm_state_pkg::xpose(data_i);
      end else if (valid_i) begin
        data_o <= data_i;
      end
    end
  end

endmodule

// ===== hw/thread_limiter.sv
// Thread dispatch gate that holds active threads under the cap
`timescale 1ns/1ps
module thread_limiter (
  input  wire logic       clk_i,      // Clock
  input  wire logic       reset_i,    // Synchronous reset
  input  wire logic [6:0] cap_i,      // Cap field, threads minus one
  input  wire logic       req_i,      // Thread waiting for dispatch
  input  wire logic       done_i,     // One thread retired
  output logic            grant_o,    // One-cycle dispatch pulse
  output logic [7:0]      active_o    // Threads now active
);

  logic [7:0] active_reg; // Active thread count
  logic       grant_reg;  // Dispatch pulse
  logic [7:0] limit;      // Cap plus one

  assign limit    = {1'b0, cap_i} + 8'h01;
  assign grant_o  = grant_reg;
  assign active_o = active_reg;

  // *****************************************************
  // Grant only when room stays after pending dispatch
  // *****************************************************
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      grant_reg <= 1'b0;
    end else begin
      grant_reg <= req_i && !grant_reg &&
                   (active_reg + {7'h00, grant_reg} < limit);
    end
  end

  // Count dispatches up and retirements down
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      active_reg <= 8'h00;
    end else if (grant_reg && !(done_i && active_reg != 8'h00)) begin
      active_reg <= active_reg + 8'h01;
    end else if (!grant_reg && done_i && active_reg != 8'h00) begin
      active_reg <= active_reg - 8'h01;
    end
  end

endmodule

// ===== hw/wm_state_ctl.sv
// Windower dispatch state: statistics, thread cap, transpose on read
//
// The placing of the registers and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ps
module wm_state_ctl (
  input  wire logic         clk_i,          // Clock, 200 MHz
  input  wire logic         reset_i,        // Synchronous reset
  // Wishbone classic slave
  input  wire logic         cyc_i,          // Bus cycle
  input  wire logic         stb_i,          // Strobe
  input  wire logic         we_i,           // Write enable
  input  wire logic [7:0]   adr_i,          // Byte address
  input  wire logic [3:0]   sel_i,          // Byte lanes
  input  wire logic [31:0]  dat_i,          // Write data
  output logic [31:0]       dat_o,          // Read data
  output logic              ack_o,          // Acknowledge
  // Pipeline traffic
  input  wire logic         prim_i,         // Primitive passed
  input  wire logic         pixel_i,        // Pixel passed
  input  wire logic         depth_pass_i,   // Pixel passed depth
  // Thread dispatch
  input  wire logic         disp_req_i,     // Thread waiting
  input  wire logic         thread_done_i,  // Thread retired
  output logic              disp_grant_o,   // Dispatch pulse
  // Buffer read path
  input  wire logic         rd_valid_i,     // Read data present
  input  wire logic         rd_kind_i,      // 0 setup, 1 constant
  input  wire logic [511:0] rd_data_i,      // Data as stored
  output logic              rd_valid_o,     // Delivered data present
  output logic [511:0]      rd_data_o       // Delivered data
);

  // *****************************************************
  // Declarations
  // *****************************************************
  // Constant payload transposed too, as the compatible model does
  localparam logic CONST_XPOSE = 1'b1;

  wm_state_pkg::wm_state_t state_reg;   // Software state word
  wm_state_pkg::stats_t    stats_reg;   // Statistics counters
  logic [7:0]              active_cnt;  // Active threads
  logic                    grant;       // Dispatch pulse
  logic                    req_hit;     // Bus request this cycle
  logic                    do_xpose;    // Transpose current read
  logic [31:0]             rd_word;     // Decoded read value
  logic                    ack_reg;     // Acknowledge flop
  logic [31:0]             dat_reg;     // Read data flop

  // Advance a counter by one when enabled and the event fires
  function automatic logic [31:0] bump(
    input logic [31:0] cnt,
    input logic        ev,
    input logic        en
  );
    logic [31:0] r;
    r = cnt;
    if (en && ev) begin
      r = cnt + 32'h0000_0001;
    end
    return r;
  endfunction

  assign req_hit = cyc_i && stb_i && !ack_reg;
  assign ack_o   = ack_reg;
  assign dat_o   = dat_reg;

  // *****************************************************
  // Bus handshake
  // *****************************************************
  // Ack one cycle after the request, then drop for a cycle
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req_hit;
    end
  end

  // Read decode, unmapped addresses read zero
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (adr_i)
      wm_state_pkg::STATS_CTL_OFS: begin
        rd_word[wm_state_pkg::STATS_EN_BIT] = state_reg.stats_en;
      end
      wm_state_pkg::DISPATCH_OFS: begin
        rd_word[wm_state_pkg::CAP_MSB:wm_state_pkg::CAP_LSB] =
          state_reg.active_thread_cap;
        rd_word[wm_state_pkg::TRANSPOSE_BIT] = state_reg.transpose_on_read;
      end
      wm_state_pkg::ACTIVE_OFS: begin
        rd_word[7:0] = active_cnt;
      end
      wm_state_pkg::PRIM_CNT_OFS: begin
        rd_word = stats_reg.prim;
      end
      wm_state_pkg::PIXEL_CNT_OFS: begin
        rd_word = stats_reg.pixel;
      end
      wm_state_pkg::INVOC_CNT_OFS: begin
        rd_word = stats_reg.pixel_shader_invocation_count;
      end
      wm_state_pkg::DEPTH_CNT_OFS: begin
        rd_word = stats_reg.pixel_depth_pass_count;
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
  end

  // Capture read data with the acknowledge
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      dat_reg <= 32'h0000_0000;
    end else if (req_hit && !we_i) begin
      dat_reg <= rd_word;
    end
  end

  // *****************************************************
  // State word writes
  // *****************************************************
  // Writes land on the edge that raises ack
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_reg.stats_en          <= wm_state_pkg::STATS_EN_RST;
      state_reg.transpose_on_read <= wm_state_pkg::TRANSPOSE_RST;
      state_reg.active_thread_cap <= wm_state_pkg::CAP_RST;
    end else if (req_hit && we_i) begin
      // Statistics enable sits in the low lane
      if (adr_i == wm_state_pkg::STATS_CTL_OFS && sel_i[0]) begin
        state_reg.stats_en <= dat_i[wm_state_pkg::STATS_EN_BIT];
      end
      // Cap and transpose share the top lane
      if (adr_i == wm_state_pkg::DISPATCH_OFS && sel_i[3]) begin
        state_reg.active_thread_cap <=
          dat_i[wm_state_pkg::CAP_MSB:wm_state_pkg::CAP_LSB];
        state_reg.transpose_on_read <= dat_i[wm_state_pkg::TRANSPOSE_BIT];
      end
    end
  end

  // *****************************************************
  // Statistics counters
  // *****************************************************
  // Each counter moves only while statistics are enabled
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      stats_reg <= '0;
    end else begin
      stats_reg.prim  <= bump(stats_reg.prim, prim_i, state_reg.stats_en);
      stats_reg.pixel <= bump(stats_reg.pixel, pixel_i, state_reg.stats_en);
      // Invocations count real dispatches
      stats_reg.pixel_shader_invocation_count <=
        bump(stats_reg.pixel_shader_invocation_count, grant,
             state_reg.stats_en);
      stats_reg.pixel_depth_pass_count <=
        bump(stats_reg.pixel_depth_pass_count, depth_pass_i,
             state_reg.stats_en);
    end
  end

  // *****************************************************
  // Thread dispatch gate
  // *****************************************************
  thread_limiter u_limiter (
    .clk_i    (clk_i),
    .reset_i  (reset_i),
    .cap_i    (state_reg.active_thread_cap),
    .req_i    (disp_req_i),
    .done_i   (thread_done_i),
    .grant_o  (grant),
    .active_o (active_cnt)
  );

  assign disp_grant_o = grant;

  // *****************************************************
  // Buffer read path
  // *****************************************************
  // Setup coefficients and constants both follow the bit, since CONST_XPOSE is set
  always_comb begin
    do_xpose = 1'b0;
    if (state_reg.transpose_on_read) begin
      if (rd_kind_i == wm_state_pkg::READ_SETUP) begin
        do_xpose = 1'b1;
      end else begin
        do_xpose = CONST_XPOSE;
      end
    end
  end

  read_transposer u_xpose (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .valid_i (rd_valid_i),
    .data_i  (rd_data_i),
    .xpose_i (do_xpose),
    .valid_o (rd_valid_o),
    .data_o  (rd_data_o)
  );

  // *****************************************************
  // Checks
  // *****************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  logic [8:0] room_used; // Active plus pending dispatch

  assign room_used = {1'b0, active_cnt} + {8'h00, grant};

  stats_hold_a: assert property (
    !state_reg.stats_en |=> $stable(stats_reg))
    else $error("statistics moved while disabled");

  prim_count_a: assert property (
    state_reg.stats_en && prim_i |=> stats_reg.prim == $past(stats_reg.prim) + 32'h1)
    else $error("primitive count missed an event");

  invoc_count_a: assert property (
    state_reg.stats_en && grant |=>
      stats_reg.pixel_shader_invocation_count ==
      $past(stats_reg.pixel_shader_invocation_count) + 32'h1)
    else $error("invocation count missed a dispatch");

  cap_limit_a: assert property (
    grant |-> $past(room_used) <= {2'b00, $past(state_reg.active_thread_cap)})
    else $error("dispatch beyond thread cap");

  grant_pulse_a: assert property (
    grant |=> !grant)
    else $error("dispatch pulse longer than one cycle");

  xpose_setup_a: assert property (
    rd_valid_i && state_reg.transpose_on_read && rd_kind_i == wm_state_pkg::READ_SETUP
      |=> rd_valid_o && rd_data_o == wm_state_pkg::xpose($past(rd_data_i)))
    else $error("setup read not transposed");

  xpose_off_a: assert property (
    rd_valid_i && !state_reg.transpose_on_read |=> rd_data_o == $past(rd_data_i))
    else $error("read altered while transpose off");

  xpose_const_a: assert property (
    rd_valid_i && state_reg.transpose_on_read && rd_kind_i == wm_state_pkg::READ_CONSTANT
      |=> rd_data_o == wm_state_pkg::xpose($past(rd_data_i)))
    else $error("constant payload not transposed");

  ack_once_a: assert property (
    ack_reg |=> !ack_reg)
    else $error("ack held two cycles");

  // *****************************************************
  // Further counter, dispatch, read path and handshake checks
  // *****************************************************
  // Pixel counter follows its event while enabled
  pixel_count_a: assert property (
    state_reg.stats_en && pixel_i |=> stats_reg.pixel == $past(stats_reg.pixel) + 32'h1)
    else $error("pixel count missed an event");

  // Depth pass counter follows its event while enabled
  depth_count_a: assert property (
    state_reg.stats_en && depth_pass_i |=>
      stats_reg.pixel_depth_pass_count == $past(stats_reg.pixel_depth_pass_count) + 32'h1)
    else $error("depth pass count missed an event");

  // Dispatches while disabled leave the invocation count alone
  invoc_hold_a: assert property (
    !state_reg.stats_en |=> $stable(stats_reg.pixel_shader_invocation_count))
    else $error("invocation count moved while disabled");

  // A granted thread never finds the pool already beyond the cap
  grant_room_a: assert property (
    grant |-> active_cnt <= {1'b0, $past(state_reg.active_thread_cap)})
    else $error("dispatch granted with no room");

  // Every read beat is delivered one cycle later
  read_valid_a: assert property (
    rd_valid_i |=> rd_valid_o)
    else $error("read beat lost");

  // No delivery without a read beat behind it
  read_quiet_a: assert property (
    !rd_valid_i |=> !rd_valid_o)
    else $error("delivery without a read beat");

  // A fresh bus request is answered on the next edge
  ack_answer_a: assert property (
    cyc_i && stb_i && !ack_reg |=> ack_reg)
    else $error("bus request not acknowledged");

  // *****************************************************
  // Scenario covers
  // *****************************************************
  cap_reached_c: cover property (grant ##1 room_used == {2'b00, state_reg.active_thread_cap} + 9'h1);
  xposed_read_c: cover property (rd_valid_i && state_reg.transpose_on_read);
  stats_off_c: cover property (!state_reg.stats_en && pixel_i);
  grant_off_c: cover property (!state_reg.stats_en && grant);
  straight_read_c: cover property (rd_valid_i && !state_reg.transpose_on_read);

endmodule

// ===== hw/wm_state_pkg.sv
// Constants, carriers and helpers shared by the windower state control
package wm_state_pkg;

  // *****************************************************
  // Register map (byte addresses)
  // *****************************************************
  localparam logic [7:0] STATS_CTL_OFS   = 8'h00; // Statistics enable
  localparam logic [7:0] DISPATCH_OFS    = 8'h04; // Thread cap and transpose
  localparam logic [7:0] ACTIVE_OFS      = 8'h08; // Active thread count
  localparam logic [7:0] PRIM_CNT_OFS    = 8'h0c; // Primitive counter
  localparam logic [7:0] PIXEL_CNT_OFS   = 8'h10; // Pixel counter
  localparam logic [7:0] INVOC_CNT_OFS   = 8'h14; // Shader invocation counter
  localparam logic [7:0] DEPTH_CNT_OFS   = 8'h18; // Depth pass counter

  // *****************************************************
  // Field positions and reset values
  // *****************************************************
  localparam int STATS_EN_BIT    = 0;  // Statistics enable
  localparam int CAP_LSB         = 25; // Thread cap field low bit
  localparam int CAP_MSB         = 31; // Thread cap field high bit
  localparam int TRANSPOSE_BIT   = 24; // Transpose on read
  localparam logic       STATS_EN_RST  = 1'b0;
  localparam logic       TRANSPOSE_RST = 1'b0;
  localparam logic [6:0] CAP_RST       = 7'h00;

  // Kinds of buffer read
  typedef enum logic {READ_SETUP, READ_CONSTANT} read_kind_t;

  // Dispatch state word as held by the block
  typedef struct packed {
    logic [6:0] active_thread_cap; // Thread count minus one
    logic       transpose_on_read; // Transpose setup and constant reads
    logic       stats_en;          // Statistics gathering on
  } wm_state_t;

  // The four statistics counters
  typedef struct packed {
    logic [31:0] prim;
    logic [31:0] pixel;
    logic [31:0] pixel_shader_invocation_count;
    logic [31:0] pixel_depth_pass_count;
  } stats_t;

  // Transpose a 4x4 matrix of 32-bit elements, row i column j at 4*i+j
  function automatic logic [511:0] xpose(input logic [511:0] d);
    logic [511:0] r;
    r = '0;
    for (int i = 0; i < 4; i++) begin
      for (int j = 0; j < 4; j++) begin
        r[32*(4*j+i) +: 32] = d[32*(4*i+j) +: 32];
      end
    end
    return r;
  endfunction

endpackage

// ===== tb/thread_pool.sv
// Behavioural model of the shader threads that the dispatcher launches
`timescale 1ns/1ps
module thread_pool (
  input  wire logic       clk_i,    // Clock
  input  wire logic       reset_i,  // Synchronous reset
  input  wire logic       grant_i,  // One thread launched
  input  wire logic       slow_i,   // Long thread lifetime
  output logic            done_o,   // One thread retired
  output logic [7:0]      live_o    // Threads now running
);
  // ***************************************
  // Lifetime timer
  // ***************************************
  logic [7:0] wait_reg;             // Cycles until next retirement

  // Retires one thread per expired wait, never with none running
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      live_o   <= 8'h00;
      done_o   <= 1'b0;
      wait_reg <= 8'h00;
    end else begin
      live_o <= live_o + {7'h00, grant_i} - {7'h00, done_o};
      done_o <= 1'b0;
      if (live_o == 8'h00 || done_o) begin
        // Idle or just retired: restart the lifetime
        wait_reg <= slow_i ? 8'h28 : 8'h03;
      end else if (wait_reg != 8'h00) begin
        wait_reg <= wait_reg - 8'h01;
      end else begin
        done_o <= 1'b1;
      end
    end
  end
endmodule

// ===== tb/windower_dispatch_state_ctl_test.sv
// Self-checking bench for the windower dispatch state control
`timescale 1ns/1ps
module windower_dispatch_state_ctl_test;
  // ***************************************
  // Signals
  // ***************************************
  logic clk_i, reset_i, cyc_i, stb_i, we_i, ack_o, slow, done, xp_set;
  logic prim_i, pixel_i, depth_pass_i, disp_req_i, disp_grant_o;
  logic rd_valid_i, rd_kind_i, rd_valid_o;
  logic [7:0]   adr_i, seed, live;
  logic [3:0]   sel_i;
  logic [31:0]  dat_i, dat_o, np, nx, nd;
  logic [511:0] rd_data_i, rd_data_o;
  logic [6:0]   cap_set;
  logic [31:0]  bq[$];              // Expected bus reads
  logic [511:0] dq[$];              // Expected delivered beats
  int bad_count, checks_done;

  wm_state_ctl dut (.clk_i(clk_i), .reset_i(reset_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .prim_i(prim_i), .pixel_i(pixel_i), .depth_pass_i(depth_pass_i),
    .disp_req_i(disp_req_i), .thread_done_i(done), .disp_grant_o(disp_grant_o),
    .rd_valid_i(rd_valid_i), .rd_kind_i(rd_kind_i), .rd_data_i(rd_data_i),
    .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o));
  thread_pool pool (.clk_i(clk_i), .reset_i(reset_i), .grant_i(disp_grant_o),
    .slow_i(slow), .done_o(done), .live_o(live));

  // ***************************************
  // Helpers
  // ***************************************
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // Element at 4i+j moves to 4j+i
  function automatic logic [511:0] tx(input logic [511:0] d);
    logic [511:0] r;
    for (int k = 0; k < 16; k++) r[32*(4*(k%4)+k/4) +: 32] = d[32*k +: 32];
    return r;
  endfunction
  task automatic cmp(input logic [511:0] got, input logic [511:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // Classic single cycle, held until ack
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= d; sel_i <= 4'hf;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    cyc_i <= 1'b0; stb_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bq.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  // Random traffic events, counted only while gathering is on
  task automatic ev(input int n, input logic on);
    repeat (n) begin
      @(posedge clk_i);
      seed = lfsr(seed);
      prim_i <= seed[0]; pixel_i <= seed[1]; depth_pass_i <= seed[2];
      if (on) begin
        np = np + 32'(seed[0]); nx = nx + 32'(seed[1]); nd = nd + 32'(seed[2]);
      end
    end
    @(posedge clk_i);
    prim_i <= 1'b0; pixel_i <= 1'b0; depth_pass_i <= 1'b0;
  endtask
  // Request threads one by one, holding each until granted
  task automatic disp(input int n);
    repeat (n) begin
      @(posedge clk_i);
      disp_req_i <= 1'b1;
      do @(posedge clk_i); while (disp_grant_o !== 1'b1);
      disp_req_i <= 1'b0;
    end
  endtask
  task automatic setcap(input logic [6:0] c, input logic x);
    cap_set = c; xp_set = x;
    bus(1'b1, 8'h04, {c, x, 24'h000000});
  endtask
  // Back-to-back random beats, kinds alternating
  task automatic beats(input int n);
    logic [511:0] d;
    for (int i = 0; i < n; i++) begin
      for (int k = 0; k < 64; k++) begin
        seed = lfsr(seed);
        d[8*k +: 8] = seed;
      end
      @(posedge clk_i);
      rd_valid_i <= 1'b1; rd_kind_i <= i[0]; rd_data_i <= d;
      dq.push_back(xp_set ? tx(d) : d);
    end
    @(posedge clk_i);
    rd_valid_i <= 1'b0;
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ***************************************
  // Clock, monitor, watchdog
  // ***************************************
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  // Takes the oldest note whenever a result appears
  always @(posedge clk_i) begin
    if (ack_o === 1'b1 && we_i === 1'b0) cmp(dat_o, bq.pop_front());
    if (rd_valid_o === 1'b1) cmp(rd_data_o, dq.pop_front());
    if (disp_grant_o === 1'b1) cmp(live <= {1'b0, cap_set}, 1'b1);
  end
  initial begin
    repeat (5000) @(posedge clk_i);
    bad_count++;
    complete_run;
  end

  // ***************************************
  // Main sequence
  // ***************************************
  initial begin
    {reset_i, cyc_i, stb_i, we_i, prim_i, pixel_i, depth_pass_i} = 7'h40;
    {disp_req_i, rd_valid_i, rd_kind_i, slow, xp_set} = 5'h00;
    adr_i = 8'h00; sel_i = 4'h0; dat_i = 32'h0; rd_data_i = '0; cap_set = 7'h00;
    seed = 8'h4e; np = 32'h0; nx = 32'h0; nd = 32'h0;
    repeat (12) @(posedge clk_i);
    reset_i <= 1'b0;
    rd(8'h04, 32'h0);
    rd(8'h40, 32'h0);
    bus(1'b1, 8'h00, 32'h1);
    ev(40, 1'b1);
    rd(8'h0c, np);
    rd(8'h10, nx);
    rd(8'h18, nd);
    bus(1'b1, 8'h0c, 32'hffffffff);
    rd(8'h0c, np);
    bus(1'b1, 8'h00, 32'h0);
    ev(40, 1'b0);
    rd(8'h0c, np);
    rd(8'h10, nx);
    rd(8'h18, nd);
    bus(1'b1, 8'h00, 32'h1);
    setcap(7'h02, 1'b1);
    slow <= 1'b1;
    fork
      disp(6);
      begin
        repeat (20) @(posedge clk_i);
        rd(8'h08, 32'h3);
      end
    join
    rd(8'h14, 32'h6);
    slow <= 1'b0;
    setcap(7'h00, 1'b1);
    disp(3);
    bus(1'b1, 8'h00, 32'h0);
    disp(1);
    rd(8'h14, 32'h9);
    beats(4);
    setcap(7'h01, 1'b0);
    beats(2);
    repeat (4) @(posedge clk_i);
    complete_run;
  end
endmodule
